// [epce_defines.svh]
// Offsets, field positions, reset values and timing counts of the engine.
`ifndef EPCE_DEFINES_SVH
`define EPCE_DEFINES_SVH
`define EPCE_OFF_DATA 3'h0
`define EPCE_OFF_STATUS 3'h1
`define EPCE_OFF_CONTROL 3'h2
`define EPCE_OFF_EPP_ADDR 3'h3
`define EPCE_OFF_EPP_DATA0 3'h4
`define EPCE_CTL_STROBE 0
`define EPCE_CTL_AUTOFD 1
`define EPCE_CTL_INIT 2
`define EPCE_CTL_SELECT 3
`define EPCE_CTL_DIR 5
`define EPCE_STS_TIMEOUT 0
`define EPCE_STS_PERIPH_INTERRUPT 1
`define EPCE_CTL_RESET 6'h04
`define EPCE_CLK_MHZ 200
`define EPCE_TIMEOUT_US 10
`define EPCE_TIMEOUT_CYC (`EPCE_TIMEOUT_US * `EPCE_CLK_MHZ)
`define EPCE_PERIPH_DELAY 4'h3
`endif

// [epce_pkg.sv]
// Types shared by the two ends of the parallel cycle engine.
package epce_pkg;
    typedef enum logic [2:0] {
        EPCE_IDLE, EPCE_WAIT_RDY, EPCE_STROBE, EPCE_HOLD, EPCE_DONE
    } epce_state_type;
    typedef enum logic [1:0] {
        EPCE_P_IDLE, EPCE_P_SETUP, EPCE_P_ACK
    } epce_pstate_type;
endpackage

// [epce_link_if.sv]
// Parallel port wires joining the controller end and the peripheral end.
`timescale 1ns/1ps
interface epce_link_if;
    logic [7:0] periph_bus_host;
    logic periph_bus_host_oe;
    logic [7:0] periph_bus_dev;
    logic periph_bus_dev_oe;
    logic write_indicator_n;
    logic data_strobe_out_n;
    logic addr_strobe_out_n;
    logic port_direction_out;
    logic peripheral_wait_n;
    logic periph_interrupt;
    logic periph_reset_n;
    logic autofeed_n;
    logic select_n;
    modport host (
        output periph_bus_host, periph_bus_host_oe, write_indicator_n,
        output data_strobe_out_n, addr_strobe_out_n, port_direction_out,
        output periph_reset_n, autofeed_n, select_n,
        input periph_bus_dev, periph_bus_dev_oe,
        input peripheral_wait_n, periph_interrupt
    );
    modport periph (
        input periph_bus_host, periph_bus_host_oe, write_indicator_n,
        input data_strobe_out_n, addr_strobe_out_n, port_direction_out,
        input periph_reset_n,
        output periph_bus_dev, periph_bus_dev_oe,
        output peripheral_wait_n, periph_interrupt
    );
endinterface

// [epce_periph.sv]
// Peripheral end: answers strobes with the interlocked wait handshake.
`timescale 1ns/1ps
`include "epce_defines.svh"
module epce_periph (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Link
    epce_link_if.periph link,
    // User side
    input wire logic [7:0] rd_data_i,
    input wire logic irq_i,
    output logic [7:0] wr_data_o,
    output logic wr_addr_o,
    output logic wr_valid_o
);
    logic [1:0] ds_sync_reg, as_sync_reg, wr_sync_reg;
    logic [3:0] cnt_reg;
    logic bus_oe_reg;
    logic wait_n_reg;
    logic irq_reg;
    logic [7:0] bus_reg;
    epce_pkg::epce_pstate_type st_reg;
    logic strobe;
    logic is_addr;
    assign strobe = ~ds_sync_reg[1] | ~as_sync_reg[1];
    assign is_addr = ~as_sync_reg[1];
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ds_sync_reg <= 2'h3;
            as_sync_reg <= 2'h3;
            wr_sync_reg <= 2'h3;
        end else begin
            ds_sync_reg <= {ds_sync_reg[0], link.data_strobe_out_n};
            as_sync_reg <= {as_sync_reg[0], link.addr_strobe_out_n};
            wr_sync_reg <= {wr_sync_reg[0], link.write_indicator_n};
        end
    end
    // -----------------------------------------------------------------
    // Handshake
    // -----------------------------------------------------------------
    // Wait low means ready for the next transfer; high acknowledges it.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_reg <= epce_pkg::EPCE_P_IDLE;
            cnt_reg <= 4'h0;
            wait_n_reg <= 1'b0;
            bus_oe_reg <= 1'b0;
            bus_reg <= 8'h00;
            wr_data_o <= 8'h00;
            wr_addr_o <= 1'b0;
            wr_valid_o <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            wr_valid_o <= 1'b0;
            irq_reg <= irq_i;
            unique case (st_reg)
                epce_pkg::EPCE_P_IDLE: begin
                    if (strobe) begin
                        st_reg <= epce_pkg::EPCE_P_SETUP;
                        cnt_reg <= `EPCE_PERIPH_DELAY;
                        if (wr_sync_reg[1]) begin
                            bus_oe_reg <= 1'b1;
                            bus_reg <= rd_data_i;
                        end
                    end
                end
                epce_pkg::EPCE_P_SETUP: begin
                    if (cnt_reg != 4'h0) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end else begin
                        if (!wr_sync_reg[1]) begin
                            wr_data_o <= link.periph_bus_host;
                            wr_addr_o <= is_addr;
                            wr_valid_o <= 1'b1;
                        end
                        wait_n_reg <= 1'b1;
                        st_reg <= epce_pkg::EPCE_P_ACK;
                    end
                end
                epce_pkg::EPCE_P_ACK: begin
                    if (!strobe) begin
                        bus_oe_reg <= 1'b0;
                        wait_n_reg <= 1'b0;
                        st_reg <= epce_pkg::EPCE_P_IDLE;
                    end
                end
            endcase
            if (!link.periph_reset_n) begin
                st_reg <= epce_pkg::EPCE_P_IDLE;
                wait_n_reg <= 1'b0;
                bus_oe_reg <= 1'b0;
            end
        end
    end
    assign link.periph_bus_dev = bus_reg;
    assign link.periph_bus_dev_oe = bus_oe_reg;
    assign link.peripheral_wait_n = wait_n_reg;
    assign link.periph_interrupt = irq_reg;
endmodule // epce_periph

// [epce_host.sv]
// Controller end: turns EPP host port accesses into parallel strobe cycles.
`timescale 1ns/1ps
`include "epce_defines.svh"
module epce_host (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Host register port
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic epp_mode_i,
    input wire logic newer_variant_i,
    input wire logic periph_reset_i,
    output logic [7:0] rdata_o,
    output logic ready_o,
    output logic periph_interrupt_o,
    // Link
    epce_link_if.host link
);
    // -----------------------------------------------------------------
    // Synchronisers
    // -----------------------------------------------------------------
    logic [1:0] wait_sync_reg, periph_interrupt_sync_reg;
    logic [7:0] pbus_s1_reg, pbus_s2_reg;
    logic wait_n;
    assign wait_n = wait_sync_reg[1];
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wait_sync_reg <= 2'h0;
            periph_interrupt_sync_reg <= 2'h0;
            pbus_s1_reg <= 8'h00;
            pbus_s2_reg <= 8'h00;
        end else begin
            wait_sync_reg <= {wait_sync_reg[0], link.peripheral_wait_n};
            periph_interrupt_sync_reg <= {periph_interrupt_sync_reg[0], link.periph_interrupt};
            pbus_s1_reg <= link.periph_bus_dev;
            pbus_s2_reg <= pbus_s1_reg;
        end
    end
    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    logic [5:0] ctl_reg;
    logic [7:0] spp_data_reg;
    logic [7:0] epp_out_reg;
    logic [7:0] epp_in_reg;
    logic tmo_reg;
    logic periph_interrupt_rise_reg;
    logic [15:0] wdog_reg;
    logic is_write_reg, is_addr_reg;
    epce_pkg::epce_state_type st_reg;
    logic epp_sel;
    logic in_cycle;
    logic wdog_expired;
    assign epp_sel = epp_mode_i && (addr_i >= `EPCE_OFF_EPP_ADDR);
    assign in_cycle = (st_reg != epce_pkg::EPCE_IDLE);
    assign wdog_expired = (wdog_reg == 16'(`EPCE_TIMEOUT_CYC));
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctl_reg <= `EPCE_CTL_RESET;
            spp_data_reg <= 8'h00;
        end else if (wr_i && addr_i == `EPCE_OFF_CONTROL) begin
            ctl_reg <= wdata_i[5:0];
        end else if (wr_i && addr_i == `EPCE_OFF_DATA) begin
            spp_data_reg <= wdata_i;
        end
    end
    // Timeout flag: a new timeout wins over the read that clears it.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tmo_reg <= 1'b0;
            periph_interrupt_rise_reg <= 1'b0;
        end else begin
            periph_interrupt_rise_reg <= periph_interrupt_sync_reg[1];
            if (in_cycle && wdog_expired) begin
                tmo_reg <= 1'b1;
            end else if (rd_i && addr_i == `EPCE_OFF_STATUS) begin
                tmo_reg <= 1'b0;
            end
        end
    end
    // -----------------------------------------------------------------
    // Cycle engine
    // -----------------------------------------------------------------
    // The host port never stalls; ready_o reports the stretch instead, and
    // a read result is returned by re-reading after ready_o goes high.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_reg <= epce_pkg::EPCE_IDLE;
            wdog_reg <= 16'h0000;
            is_write_reg <= 1'b0;
            is_addr_reg <= 1'b0;
            epp_out_reg <= 8'h00;
            epp_in_reg <= 8'h00;
        end else begin
            wdog_reg <= in_cycle ? wdog_reg + 16'h0001 : 16'h0000;
            unique case (st_reg)
                epce_pkg::EPCE_IDLE: begin
                    if ((wr_i || rd_i) && epp_sel) begin
                        is_write_reg <= wr_i;
                        is_addr_reg <= (addr_i
                            == `EPCE_OFF_EPP_ADDR);
                        if (wr_i) begin
                            epp_out_reg <= wdata_i;
                        end
                        // An older cycle also waits out a stale acknowledge,
                        // or a new strobe would end on the last cycle's wait.
                        st_reg <= (newer_variant_i || wait_n)
                            ? epce_pkg::EPCE_WAIT_RDY
                            : epce_pkg::EPCE_STROBE;
                    end
                end
                epce_pkg::EPCE_WAIT_RDY: begin
                    if (!wait_n) begin
                        st_reg <= epce_pkg::EPCE_STROBE;
                    end
                end
                epce_pkg::EPCE_STROBE: begin
                    if (wait_n) begin
                        if (!is_write_reg) begin
                            epp_in_reg <= pbus_s2_reg;
                        end
                        st_reg <= epce_pkg::EPCE_HOLD;
                    end
                end
                epce_pkg::EPCE_HOLD: begin
                    if (!wait_n || !newer_variant_i) begin
                        st_reg <= epce_pkg::EPCE_DONE;
                    end
                end
                epce_pkg::EPCE_DONE: begin
                    st_reg <= epce_pkg::EPCE_IDLE;
                end
            endcase
            if (in_cycle && wdog_expired) begin
                st_reg <= epce_pkg::EPCE_IDLE;
            end
        end
    end
    // -----------------------------------------------------------------
    // Pins
    // -----------------------------------------------------------------
    logic strobing;
    logic epp_read;
    logic force_wr;
    logic wr_ind_n_next;
    assign strobing = (st_reg == epce_pkg::EPCE_STROBE)
        && !wdog_expired;
    assign epp_read = in_cycle && !is_write_reg;
    assign force_wr = in_cycle && ctl_reg[`EPCE_CTL_STROBE];
    // Write indicator, like direction and bus drive, is still forced by the control register's strobe bit during a cycle.
    assign wr_ind_n_next = in_cycle
        ? ((is_write_reg || force_wr) ? 1'b0 : 1'b1)
        : ctl_reg[`EPCE_CTL_DIR];
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            link.write_indicator_n <= 1'b1;
            link.data_strobe_out_n <= 1'b1;
            link.addr_strobe_out_n <= 1'b1;
            link.port_direction_out <= 1'b0;
            link.periph_bus_host <= 8'h00;
            link.periph_bus_host_oe <= 1'b1;
            link.periph_reset_n <= 1'b0;
            link.autofeed_n <= 1'b1;
            link.select_n <= 1'b1;
            ready_o <= 1'b1;
            periph_interrupt_o <= 1'b0;
            rdata_o <= 8'h00;
        end else begin
            link.write_indicator_n <= wr_ind_n_next;
            link.data_strobe_out_n <= in_cycle
                ? ~(strobing && !is_addr_reg)
                : ~ctl_reg[`EPCE_CTL_STROBE];
            link.addr_strobe_out_n <= ~(strobing && is_addr_reg);
            link.port_direction_out <= force_wr ? 1'b0
                : (epp_read || ctl_reg[`EPCE_CTL_DIR]);
            link.periph_bus_host_oe <= force_wr
                || (in_cycle ? is_write_reg
                             : !ctl_reg[`EPCE_CTL_DIR]);
            link.periph_bus_host <= in_cycle ? epp_out_reg : spp_data_reg;
            link.periph_reset_n <= ctl_reg[`EPCE_CTL_INIT]
                && !periph_reset_i;
            link.autofeed_n <= ~ctl_reg[`EPCE_CTL_AUTOFD];
            link.select_n <= ~ctl_reg[`EPCE_CTL_SELECT];
            // Ready drops with the access and rises once the cycle ends.
            ready_o <= !(((wr_i || rd_i) && epp_sel && !in_cycle)
                || (in_cycle && st_reg != epce_pkg::EPCE_DONE
                    && !wdog_expired));
            periph_interrupt_o <= periph_interrupt_sync_reg[1] && !periph_interrupt_rise_reg;
            if (rd_i) begin
                unique case (addr_i)
                    `EPCE_OFF_DATA: rdata_o <= pbus_s2_reg;
                    `EPCE_OFF_STATUS: rdata_o <= {6'h00, periph_interrupt_sync_reg[1],
                                                  tmo_reg};
                    `EPCE_OFF_CONTROL: rdata_o <= {2'h0, ctl_reg};
                    default: rdata_o <= epp_mode_i ? epp_in_reg
                                                   : 8'h00;
                endcase
            end
        end
    end
endmodule // epce_host

// [epce_link_sva.sv]
// Concurrent checks on the parallel link between the two design ends.
`timescale 1ns/1ps
module epce_link_sva (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Link signals
    input wire logic periph_bus_host_oe,
    input wire logic periph_bus_dev_oe,
    input wire logic write_indicator_n,
    input wire logic data_strobe_out_n,
    input wire logic addr_strobe_out_n,
    input wire logic port_direction_out,
    input wire logic peripheral_wait_n
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    logic stb_n;
    assign stb_n = data_strobe_out_n & addr_strobe_out_n;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_one_strobe;
        !data_strobe_out_n |-> addr_strobe_out_n;
    endproperty
    property p_read_released;
        !stb_n && write_indicator_n
            |-> !periph_bus_host_oe && port_direction_out;
    endproperty
    property p_write_driven;
        !stb_n && !write_indicator_n
            |-> periph_bus_host_oe && !port_direction_out;
    endproperty
    property p_dir_means_read;
        port_direction_out |-> write_indicator_n;
    endproperty
    property p_ack_bounded;
        $fell(stb_n) |-> ##[1:12] peripheral_wait_n;
    endproperty
    property p_strobe_waits;
        !stb_n && !peripheral_wait_n |=> !stb_n;
    endproperty
    property p_strobe_ends;
        $rose(peripheral_wait_n) |-> ##[1:5] stb_n;
    endproperty
    property p_wait_returns;
        $rose(stb_n) |-> ##[0:8] !peripheral_wait_n;
    endproperty
    property p_bus_freed;
        $fell(peripheral_wait_n) |-> ##[0:2] !periph_bus_dev_oe;
    endproperty
    property p_indicator_steady;
        !stb_n ##1 !stb_n |-> $stable(write_indicator_n);
    endproperty
    // ------------------------------------------------------------
    // Assertions and covers
    // ------------------------------------------------------------
    a_one_strobe: assert property (p_one_strobe)
        else $error("both strobes low together");
    a_read_released: assert property (p_read_released)
        else $error("read strobe while bus driven or direction low");
    a_write_driven: assert property (p_write_driven)
        else $error("write strobe without bus drive");
    a_dir_means_read: assert property (p_dir_means_read)
        else $error("direction high while write indicated");
    a_ack_bounded: assert property (p_ack_bounded)
        else $error("peripheral did not acknowledge strobe");
    a_strobe_waits: assert property (p_strobe_waits)
        else $error("strobe dropped before peripheral acknowledge");
    a_strobe_ends: assert property (p_strobe_ends)
        else $error("strobe held after acknowledge");
    a_wait_returns: assert property (p_wait_returns)
        else $error("wait not reasserted after strobe");
    a_bus_freed: assert property (p_bus_freed)
        else $error("peripheral still drives bus after cycle");
    a_indicator_steady: assert property (p_indicator_steady)
        else $error("write indicator moved under strobe");
    c_addr: cover property (!addr_strobe_out_n);
    c_read: cover property ($fell(stb_n) && write_indicator_n);
    c_write: cover property ($fell(stb_n) && !write_indicator_n);
endmodule // epce_link_sva

// [testbench.sv]
// Self-checking bench joining the controller and peripheral ends.
`timescale 1ns/1ps
`include "epce_defines.svh"
module testbench;
    logic clk_sys_i, sys_rst_i, epp_mode, newer, prst, irq, ready0, ready1;
    logic intr0, wr_addr, wr_valid, got_a, seen_a, seen_d;
    logic [2:0] addr, a;
    logic [7:0] wdata, rd_data, rdata0, rdata1, wr_data, got_d, q;
    logic [1:0] wr_m, rd_m;
    logic [31:0] lfsr;
    int fail_count, checks_done, cyc, nwr, nintr, n, base;
    epce_link_if link();
    epce_link_if link_t();
    // A stalled peripheral that never acknowledges and leaves its bus.
    assign link_t.peripheral_wait_n = 1'b0;
    assign link_t.periph_bus_dev_oe = 1'b0;
    assign link_t.periph_bus_dev = lfsr[7:0];
    assign link_t.periph_interrupt = 1'b0;
    epce_host epce_host_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr_m[0]), .rd_i(rd_m[0]),
        .epp_mode_i(epp_mode), .newer_variant_i(newer), .periph_reset_i(prst),
        .rdata_o(rdata0), .ready_o(ready0), .periph_interrupt_o(intr0), .link(link.host));
    epce_host epce_host_tmo_inst (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr_m[1]), .rd_i(rd_m[1]), .epp_mode_i(1'b1),
        .newer_variant_i(1'b0), .periph_reset_i(1'b0), .rdata_o(rdata1),
        .ready_o(ready1), .periph_interrupt_o(), .link(link_t.host));
    epce_periph epce_periph_inst (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .link(link.periph), .rd_data_i(rd_data),
        .irq_i(irq), .wr_data_o(wr_data), .wr_addr_o(wr_addr),
        .wr_valid_o(wr_valid));
    epce_link_sva epce_link_sva_inst (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .periph_bus_host_oe(link.periph_bus_host_oe),
        .periph_bus_dev_oe(link.periph_bus_dev_oe),
        .write_indicator_n(link.write_indicator_n),
        .data_strobe_out_n(link.data_strobe_out_n),
        .addr_strobe_out_n(link.addr_strobe_out_n),
        .port_direction_out(link.port_direction_out),
        .peripheral_wait_n(link.peripheral_wait_n));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [7:0] kind(input logic [2:0] p);
        return (p == `EPCE_OFF_EPP_ADDR) ? 8'h02 : 8'h01;
    endfunction
    function automatic logic [7:0] pins();
        return {4'h0, link.autofeed_n, link.select_n,
            link.port_direction_out, link.periph_reset_n};
    endfunction
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Each access ends at a falling edge, so strobes never collide.
    task automatic bus_wr(input logic s, input logic [2:0] p,
        input logic [7:0] d);
        @(posedge clk_sys_i);
        addr <= p;
        wdata <= d;
        wr_m[s] <= 1'b1;
        @(posedge clk_sys_i);
        wr_m <= 2'b00;
        @(negedge clk_sys_i);
    endtask
    task automatic bus_rd(input logic s, input logic [2:0] p);
        @(posedge clk_sys_i);
        addr <= p;
        rd_m[s] <= 1'b1;
        @(posedge clk_sys_i);
        rd_m <= 2'b00;
        @(negedge clk_sys_i);
        q = s ? rdata1 : rdata0;
    endtask
    task automatic wait_ready(input logic s);
        n = 0;
        do begin
            @(negedge clk_sys_i);
            n++;
        end while ((s ? ready1 : ready0) !== 1'b1 && n < 3000);
        check("ready_back", {7'h00, s ? ready1 : ready0}, 8'h01);
    endtask
    task automatic epp_write(input logic [2:0] p, input logic [7:0] d);
        base = nwr;
        seen_a = 1'b0;
        seen_d = 1'b0;
        bus_wr(0, `EPCE_OFF_CONTROL, 8'h04);
        bus_wr(0, p, d);
        check("ready_low", {7'h00, ready0}, 8'h00);
        wait_ready(0);
        repeat (4) @(negedge clk_sys_i);
        check("wr_count", 8'(nwr - base), 8'h01);
        check("wr_data", got_d, d);
        check("wr_port", {7'h00, got_a}, kind(p) - 8'h01);
        check("strobe_kind", {6'h00, seen_a, seen_d}, kind(p));
    endtask
    task automatic epp_read(input logic [2:0] p, input logic [7:0] d,
        input logic nv);
        newer = nv;
        rd_data = d;
        seen_a = 1'b0;
        seen_d = 1'b0;
        bus_wr(0, `EPCE_OFF_CONTROL, nv ? 8'h04 : 8'h24);
        bus_rd(0, p);
        check("ready_low", {7'h00, ready0}, 8'h00);
        wait_ready(0);
        check("strobe_kind", {6'h00, seen_a, seen_d}, kind(p));
        bus_rd(0, p);
        check("rd_data", q, d);
        wait_ready(0);
    endtask
    // ------------------------------------------------------------
    // Clock, monitors and main sequence
    // ------------------------------------------------------------
    always #2.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (wr_valid === 1'b1) begin
            nwr <= nwr + 1;
            got_d <= wr_data;
            got_a <= wr_addr;
        end
        if (intr0 === 1'b1) nintr <= nintr + 1;
        if (link.addr_strobe_out_n === 1'b0) seen_a <= 1'b1;
        if (link.data_strobe_out_n === 1'b0) seen_d <= 1'b1;
        if (cyc == 40000) begin
            fail_count++;
            test_done();
        end
    end
    initial begin
        clk_sys_i = 1'b0;
        sys_rst_i = 1'b1;
        {addr, wdata, wr_m, rd_m, rd_data} = '0;
        {epp_mode, newer, prst, irq} = 4'b1000;
        lfsr = 32'h153d;
        repeat (20) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(negedge clk_sys_i);
        bus_wr(0, `EPCE_OFF_CONTROL, 8'h2a);
        repeat (2) @(negedge clk_sys_i);
        check("idle_pins", pins(), 8'h02);
        bus_wr(0, `EPCE_OFF_CONTROL, 8'h04);
        repeat (2) @(negedge clk_sys_i);
        check("idle_pins", pins(), 8'h0d);
        prst = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        check("idle_pins", pins(), 8'h0c);
        prst = 1'b0;
        irq = 1'b1;
        repeat (10) @(negedge clk_sys_i);
        check("periph_interrupt_pulses", 8'(nintr), 8'h01);
        bus_rd(0, `EPCE_OFF_STATUS);
        check("periph_interrupt_level", {7'h00, q[`EPCE_STS_PERIPH_INTERRUPT]}, 8'h01);
        irq = 1'b0;
        epp_mode = 1'b0;
        {seen_a, seen_d} = 2'b00;
        bus_wr(0, `EPCE_OFF_EPP_DATA0, 8'h5a);
        repeat (12) @(negedge clk_sys_i);
        check("no_cycle", {5'h00, seen_a, seen_d, ready0}, 8'h01);
        check("no_write", 8'(nwr), 8'h00);
        epp_mode = 1'b1;
        for (int i = 0; i < 24; i++) begin
            lfsr = lfsr_next(lfsr);
            a = (i % 12 == 0) ? 3'h3 : (i % 12 == 1) ? 3'h7
                : 3'(3 + lfsr[15:8] % 5);
            if (i < 12) epp_write(a, (i == 1) ? 8'hff : lfsr[7:0]);
            else epp_read(a, lfsr[23:16], lfsr[24]);
        end
        base = nwr;
        bus_wr(0, `EPCE_OFF_CONTROL, 8'h04);
        bus_wr(0, `EPCE_OFF_EPP_DATA0, 8'h3c);
        bus_wr(0, 3'h5, 8'hc3);
        wait_ready(0);
        repeat (4) @(negedge clk_sys_i);
        check("busy_count", 8'(nwr - base), 8'h01);
        check("busy_data", got_d, 8'h3c);
        bus_wr(1, `EPCE_OFF_CONTROL, 8'h24);
        bus_rd(1, `EPCE_OFF_EPP_DATA0);
        wait_ready(1);
        check("timeout_len", {7'h00, n >= `EPCE_TIMEOUT_CYC - 8
            && n <= `EPCE_TIMEOUT_CYC + 8}, 8'h01);
        check("abort_strobe", {7'h00, link_t.data_strobe_out_n},
            8'h01);
        bus_rd(1, `EPCE_OFF_STATUS);
        check("tmo_flag", {7'h00, q[`EPCE_STS_TIMEOUT]}, 8'h01);
        bus_rd(1, `EPCE_OFF_STATUS);
        check("tmo_clear", {7'h00, q[`EPCE_STS_TIMEOUT]}, 8'h00);
        test_done();
    end
endmodule // testbench
